// >>> rtl/ocl_pkg.sv
// option latch package: addresses, bit layout, derived selections and timing figures
// assumes a byte-wide processor write/read port on the single 100 MHz clock
package ocl_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_OPT_ONE = 16'h001e;
    localparam logic [15:0] ADDR_OPT_TWO = 16'h001f;
    // option_reg_one bit positions
    localparam int B1_WDOG_DIS = 0;
    localparam int B1_STOP_EN = 1;
    localparam int B1_SHORT_REC = 2;
    localparam int B1_TRIP_SEL = 3;
    localparam int B1_MON_PWRD = 4;
    localparam int B1_MON_RSTD = 5;
    localparam int B1_MON_STOP = 6;
    localparam int B1_WDOG_RATE = 7;
    // option_reg_two bit positions
    localparam int B2_SER_CLK = 0;
    localparam int B2_OSC_STOP = 1;
    localparam int B2_XTAL_EN = 2;
    localparam int B2_EXT_EN = 3;
    localparam int B2_SLOW_XTAL = 4;
    // reset value of both latches apart from the trip bit
    localparam logic [7:0] OPT_RESET = 8'h00;
    // base_crystal_clock cycle counts
    localparam logic [17:0] STAB_LONG = 18'h01000;  // 4096 cycles
    localparam logic [17:0] STAB_SHORT = 18'h00010; // 16 cycles
    localparam logic [17:0] REC_SHORT = 18'h00020;  // 32 cycles
    localparam logic [17:0] REC_LONG = 18'h01000;   // 4096 cycles
    localparam logic [17:0] WDOG_SHORT = 18'h01ff0; // 2^13 - 2^4
    localparam logic [17:0] WDOG_LONG = 18'h3fff0;  // 2^18 - 2^4
    // pin function of the two oscillator pins
    typedef enum logic [1:0] {OCL_PINS_GPIO, OCL_PINS_EXTCLK, OCL_PINS_XTAL} ocl_pinmode_t;
    // decoded options handed to the clock generator
    typedef struct packed {
        logic slow_crystal_select;   // 1 slow crystal, 0 fast crystal
        logic mon_expect_low;        // monitor expects below oscillator base
        logic mon_expect_crystal;    // monitor expects crystal ranges
        logic osc_run_in_stop;       // clocks continue in stop
        logic [17:0] stab_count;     // stabilization divider timeout
    } ocl_clk_cfg_t;
    // decoded supply monitor controls
    typedef struct packed {
        logic enable;                // monitor powered
        logic reset_enable;          // monitor may issue resets
        logic run_in_stop;           // monitor active in stop
        logic trip_5v;               // 1 five volt, 0 three volt
    } ocl_mon_cfg_t;
endpackage : ocl_pkg

// >>> rtl/ocl_option_latches.sv
// write-once option latches and the decoded option outputs
// assumes CPU byte strobes synchronous to MCLK and a separate power-on reset level
//
// Contract
// - slow bit picks slow crystal, else fast
// - slow bit sets monitor expected frequency side
// - pin function from external and crystal enables
// - crystal enable picks monitor crystal or external range
// - stabilization timeout 4096 with crystal, else 16
// - oscillator-in-stop keeps clocks, else forced low
// - serial clock: bus clock if set, else base
// - watchdog timeout 2^13-16 or 2^18-16, reset clears
// - monitor runs in stop when powered and set
// - reset-disable bit blocks monitor reset output
// - power-down bit disables supply monitor entirely
// - trip select 5 or 3 volt, power-on only
// - stop recovery 32 if short, else 4096
// - monitor-reset wake always uses long recovery
// - stop enable else stop is illegal opcode
// - watchdog disable bit turns watchdog off
// - one write per reset, trip kept, reads anytime
// - registers at 0x001e and 0x001f
module ocl_option_latches (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic POR_N,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WDATA,
    input wire logic MON_RESET_WAKE,
    input wire logic MON_TRIP,
    input wire logic INT_BUS_CLK,
    input wire logic BASE_CLK,
    input wire logic STOP_MODE,
    input wire logic INT_GEN_CLK_RAW,
    input wire logic EXT_GEN_CLK_RAW,
    output logic [7:0] RDATA,
    output logic [7:0] OPT_ONE,
    output logic [7:0] OPT_TWO,
    output ocl_pkg::ocl_clk_cfg_t CLK_CFG,
    output ocl_pkg::ocl_mon_cfg_t MON_CFG,
    output ocl_pkg::ocl_pinmode_t PIN_MODE,
    output logic SERIAL_PORT_CLOCK,
    output logic INTERNAL_GEN_CLOCK,
    output logic EXTERNAL_GEN_CLOCK,
    output logic [17:0] WDOG_TIMEOUT,
    output logic WDOG_ENABLE,
    output logic STOP_ALLOWED,
    output logic [17:0] STOP_RECOVERY,
    output logic MON_RESET_OUT
);
    logic [7:0] opt_one;     // option_reg_one latch
    logic [7:0] opt_two;     // option_reg_two latch
    logic trip_sel;          // trip-mode select, power-on reset only
    logic wr_one_done;       // first write seen for register one
    logic wr_two_done;       // first write seen for register two
    logic trip_hit_s1;       // synchroniser stage one
    logic trip_hit;          // synchronised monitor comparator
    logic dec_valid;         // outputs carry decoded values since reset release

    // address decode
    wire hit_one = (ADDR == ocl_pkg::ADDR_OPT_ONE);
    wire hit_two = (ADDR == ocl_pkg::ADDR_OPT_TWO);
    // a write lands only on the first write to its register after reset
    // reset level gates reg one so the trip flop cannot load mid-reset
    wire wr_one = WR_EN && hit_one && !wr_one_done && ARST_N;
    wire wr_two = WR_EN && hit_two && !wr_two_done;
    // current image including the trip bit
    wire [7:0] img_one = {opt_one[7:4], trip_sel, opt_one[2:0]};
    wire [7:0] next_rdata = !RD_EN ? RDATA : hit_one ? img_one :
                            hit_two ? opt_two : 8'h00;

    // option fields
    wire slow_x = opt_two[ocl_pkg::B2_SLOW_XTAL];
    wire ext_en = opt_two[ocl_pkg::B2_EXT_EN];
    wire xtal_en = opt_two[ocl_pkg::B2_XTAL_EN];
    wire osc_stop = opt_two[ocl_pkg::B2_OSC_STOP];
    wire ser_clk = opt_two[ocl_pkg::B2_SER_CLK];
    wire mon_pwrd = opt_one[ocl_pkg::B1_MON_PWRD];
    wire mon_rstd = opt_one[ocl_pkg::B1_MON_RSTD];
    wire mon_stop = opt_one[ocl_pkg::B1_MON_STOP];

    // decoded outputs
    ocl_pkg::ocl_clk_cfg_t next_clk;
    ocl_pkg::ocl_mon_cfg_t next_mon;
    ocl_pkg::ocl_pinmode_t next_pin;
    assign next_clk.slow_crystal_select = slow_x;
    assign next_clk.mon_expect_low = slow_x;
    assign next_clk.mon_expect_crystal = xtal_en;
    assign next_clk.osc_run_in_stop = osc_stop;
    assign next_clk.stab_count = xtal_en ? ocl_pkg::STAB_LONG : ocl_pkg::STAB_SHORT;
    assign next_mon.enable = !mon_pwrd;
    assign next_mon.reset_enable = !mon_pwrd && !mon_rstd;
    assign next_mon.run_in_stop = !mon_pwrd && mon_stop;
    assign next_mon.trip_5v = trip_sel;
    // crystal enable counts only with external enable
    assign next_pin = !ext_en ? ocl_pkg::OCL_PINS_GPIO :
                      xtal_en ? ocl_pkg::OCL_PINS_XTAL : ocl_pkg::OCL_PINS_EXTCLK;
    // clocks gated low in stop unless kept running
    wire clk_gate = !STOP_MODE || osc_stop;
    wire next_ser = ser_clk ? INT_BUS_CLK : BASE_CLK;
    wire [17:0] next_wdog = opt_one[ocl_pkg::B1_WDOG_RATE] ? ocl_pkg::WDOG_SHORT
                                                            : ocl_pkg::WDOG_LONG;
    // monitor reset wake forces long recovery
    wire [17:0] next_rec = (opt_one[ocl_pkg::B1_SHORT_REC] && !MON_RESET_WAKE) ?
                           ocl_pkg::REC_SHORT : ocl_pkg::REC_LONG;

    // write-once latches, cleared by ARST_N only, not by POR_N alone
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            opt_one <= ocl_pkg::OPT_RESET;
            opt_two <= ocl_pkg::OPT_RESET;
            wr_one_done <= 1'b0;
            wr_two_done <= 1'b0;
        end else begin
            if (wr_one) begin
                opt_one <= WDATA;
                wr_one_done <= 1'b1;
            end
            if (wr_two) begin
                opt_two <= WDATA;
                wr_two_done <= 1'b1;
            end
        end
    end

    // trip select survives ordinary resets, only power-on clears it
    always_ff @(posedge MCLK or negedge POR_N) begin
        if (!POR_N) begin
            trip_sel <= 1'b0;
        end else if (wr_one) begin
            trip_sel <= WDATA[ocl_pkg::B1_TRIP_SEL];
        end
    end

    // comparator level synchroniser
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            trip_hit_s1 <= 1'b0;
            trip_hit <= 1'b0;
        end else begin
            trip_hit_s1 <= MON_TRIP;
            trip_hit <= trip_hit_s1;
        end
    end

    // low in reset and for the first edge after it, while outputs hold reset values
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 8'h00;
            OPT_ONE <= 8'h00;
            OPT_TWO <= 8'h00;
            CLK_CFG <= '0;
            MON_CFG <= '0;
            PIN_MODE <= ocl_pkg::OCL_PINS_GPIO;
            SERIAL_PORT_CLOCK <= 1'b0;
            INTERNAL_GEN_CLOCK <= 1'b0;
            EXTERNAL_GEN_CLOCK <= 1'b0;
            WDOG_TIMEOUT <= ocl_pkg::WDOG_LONG;
            WDOG_ENABLE <= 1'b0;
            STOP_ALLOWED <= 1'b0;
            STOP_RECOVERY <= ocl_pkg::REC_LONG;
            MON_RESET_OUT <= 1'b0;
        end else begin
            RDATA <= next_rdata;
            OPT_ONE <= img_one;
            OPT_TWO <= opt_two;
            CLK_CFG <= next_clk;
            MON_CFG <= next_mon;
            PIN_MODE <= next_pin;
            SERIAL_PORT_CLOCK <= next_ser;
            INTERNAL_GEN_CLOCK <= INT_GEN_CLK_RAW && clk_gate;
            EXTERNAL_GEN_CLOCK <= EXT_GEN_CLK_RAW && clk_gate;
            WDOG_TIMEOUT <= next_wdog;
            WDOG_ENABLE <= !opt_one[ocl_pkg::B1_WDOG_DIS];
            STOP_ALLOWED <= opt_one[ocl_pkg::B1_STOP_EN];
            STOP_RECOVERY <= next_rec;
            // reset request only when powered and not disabled
            MON_RESET_OUT <= trip_hit && !mon_pwrd && !mon_rstd &&
                             (!STOP_MODE || mon_stop);
        end
    end

    // assertions; dec_valid keeps the release edge, where outputs still hold reset values, out
    // clock generator options, one cycle behind the latches
    a_slow_crystal_cfg: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> CLK_CFG.slow_crystal_select == $past(slow_x))
        else $error("slow crystal select not followed");
    a_monitor_expect_low: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> CLK_CFG.mon_expect_low == $past(slow_x))
        else $error("monitor frequency side not followed");
    a_pins_gpio_mode: assert property (@(posedge MCLK) disable iff (!ARST_N)
        !ext_en |=> PIN_MODE == ocl_pkg::OCL_PINS_GPIO)
        else $error("pins not gpio without external enable");
    a_pins_extclk_mode: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && ext_en && !xtal_en) |=> PIN_MODE == ocl_pkg::OCL_PINS_EXTCLK)
        else $error("pins not set as clock input");
    a_pins_crystal_mode: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && ext_en && xtal_en) |=> PIN_MODE == ocl_pkg::OCL_PINS_XTAL)
        else $error("pins not set for crystal");
    a_monitor_expect_xtal: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> CLK_CFG.mon_expect_crystal == $past(xtal_en))
        else $error("monitor range choice not followed");
    a_stab_count_sel: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> CLK_CFG.stab_count ==
            ($past(xtal_en) ? ocl_pkg::STAB_LONG : ocl_pkg::STAB_SHORT))
        else $error("stabilization count wrong");
    // clock gating in stop and serial clock source
    a_clock_stop_low: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (STOP_MODE && !osc_stop) |=> !INTERNAL_GEN_CLOCK && !EXTERNAL_GEN_CLOCK)
        else $error("clock ran in stop");
    a_int_clock_pass: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && (osc_stop || !STOP_MODE)) |=> INTERNAL_GEN_CLOCK == $past(INT_GEN_CLK_RAW))
        else $error("internal clock not passed");
    a_ext_clock_pass: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && (osc_stop || !STOP_MODE)) |=> EXTERNAL_GEN_CLOCK == $past(EXT_GEN_CLK_RAW))
        else $error("external clock not passed");
    a_serial_clk_src: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> SERIAL_PORT_CLOCK ==
            ($past(ser_clk) ? $past(INT_BUS_CLK) : $past(BASE_CLK)))
        else $error("serial clock source wrong");
    // watchdog controls
    a_wdog_timeout_sel: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> WDOG_TIMEOUT == ($past(opt_one[ocl_pkg::B1_WDOG_RATE]) ?
            ocl_pkg::WDOG_SHORT : ocl_pkg::WDOG_LONG))
        else $error("watchdog timeout wrong");
    a_wdog_rate_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
        $rose(dec_valid) |-> WDOG_TIMEOUT == ocl_pkg::WDOG_LONG)
        else $error("watchdog rate not cleared by reset");
    a_wdog_disable: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> WDOG_ENABLE == !$past(opt_one[ocl_pkg::B1_WDOG_DIS]))
        else $error("watchdog enable not followed");
    // supply monitor controls
    a_mon_power_down: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> MON_CFG.enable == !$past(mon_pwrd))
        else $error("monitor power not followed");
    a_mon_reset_cfg: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> MON_CFG.reset_enable == (!$past(mon_pwrd) && !$past(mon_rstd)))
        else $error("monitor reset enable wrong");
    a_mon_stop_run: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> MON_CFG.run_in_stop == ($past(mon_stop) && !$past(mon_pwrd)))
        else $error("monitor stop operation wrong");
    a_mon_stop_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
        $rose(dec_valid) |-> !MON_CFG.run_in_stop)
        else $error("monitor stop bit not cleared by reset");
    a_mon_reset_block: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (mon_rstd || mon_pwrd) |=> !MON_RESET_OUT)
        else $error("monitor reset not blocked");
    a_mon_reset_allow: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && trip_hit && !mon_pwrd && !mon_rstd && (!STOP_MODE || mon_stop))
            |=> MON_RESET_OUT)
        else $error("monitor reset not issued");
    // trip select survives ordinary resets
    a_trip_mode_out: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> MON_CFG.trip_5v == $past(trip_sel))
        else $error("trip mode not followed");
    a_trip_kept_reset: assert property (@(posedge MCLK) disable iff (!POR_N)
        !wr_one |=> trip_sel == $past(trip_sel))
        else $error("trip select changed without a write");
    a_image_one_trip: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> OPT_ONE[ocl_pkg::B1_TRIP_SEL] == $past(trip_sel))
        else $error("trip bit missing from image");
    // stop recovery length
    a_short_recovery: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (opt_one[ocl_pkg::B1_SHORT_REC] && !MON_RESET_WAKE) |=> STOP_RECOVERY == ocl_pkg::REC_SHORT)
        else $error("short recovery not applied");
    a_recovery_long_sel: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && !opt_one[ocl_pkg::B1_SHORT_REC]) |=> STOP_RECOVERY == ocl_pkg::REC_LONG)
        else $error("long recovery not applied");
    a_mon_wake_long: assert property (@(posedge MCLK) disable iff (!ARST_N)
        MON_RESET_WAKE |=> STOP_RECOVERY == ocl_pkg::REC_LONG)
        else $error("monitor wake used short recovery");
    // stop instruction enable
    a_stop_allowed: assert property (@(posedge MCLK) disable iff (!ARST_N)
        wr_one |=> ##1 STOP_ALLOWED == $past(WDATA[ocl_pkg::B1_STOP_EN], 2))
        else $error("stop enable not followed");
    a_stop_cfg_follow: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> STOP_ALLOWED == $past(opt_one[ocl_pkg::B1_STOP_EN]))
        else $error("stop enable output wrong");
    // write-once latches and reads
    a_second_write_ignored: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (WR_EN && hit_one && wr_one_done) |=> opt_one == $past(opt_one))
        else $error("second write changed option one");
    a_second_write_two: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (WR_EN && hit_two && wr_two_done) |=> opt_two == $past(opt_two))
        else $error("second write changed option two");
    a_read_data_hold: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && !RD_EN) |=> RDATA == $past(RDATA))
        else $error("read data changed without a read");
    a_read_reg_one: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && RD_EN && hit_one) |=> RDATA == $past(img_one))
        else $error("read of option one wrong");
    a_read_reg_two: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && RD_EN && hit_two) |=> RDATA == $past(opt_two))
        else $error("read of option two wrong");
    a_read_unmapped: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (dec_valid && RD_EN && !hit_one && !hit_two) |=> RDATA == '0)
        else $error("unmapped read not zero");
    a_image_two: assert property (@(posedge MCLK) disable iff (!ARST_N)
        dec_valid |=> OPT_TWO == $past(opt_two))
        else $error("option two image wrong");
endmodule // ocl_option_latches

// >>> tb/ocl_option_latches_tb_top.sv
// testbench for the option latches: write-once, decode, gating and reset checks
// assumes the design package is compiled first and one 100 MHz clock drives the block
module ocl_option_latches_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0; // bench clock
    logic arst_n = 1'b0, por_n = 1'b0; // resets, low at start
    logic [15:0] addr = 16'h0000; // cpu address
    logic [7:0] wdata = 8'h00; // write byte
    logic wr_en = 1'b0, rd_en = 1'b0, wake = 1'b0, trip = 1'b0; // strobes and levels
    logic bus_clk = 1'b0, base_clk = 1'b0, stop = 1'b0, iraw = 1'b0, eraw = 1'b0; // clock levels
    logic [7:0] rdata, opt_one, opt_two; // byte outputs
    ocl_pkg::ocl_clk_cfg_t clk_cfg; // decoded clock options
    ocl_pkg::ocl_mon_cfg_t mon_cfg; // decoded monitor options
    ocl_pkg::ocl_pinmode_t pin_mode; // oscillator pin function
    logic ser_clk, igen, egen, wdog_en, stop_ok, mon_rst; // single-bit outputs
    logic [17:0] wdog_to, stop_rec; // cycle counts
    int mismatches = 0, compares = 0; // score
    ocl_option_latches u_ocl_option_latches (.MCLK(mclk), .ARST_N(arst_n), .POR_N(por_n),
        .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .MON_RESET_WAKE(wake),
        .MON_TRIP(trip), .INT_BUS_CLK(bus_clk), .BASE_CLK(base_clk), .STOP_MODE(stop),
        .INT_GEN_CLK_RAW(iraw), .EXT_GEN_CLK_RAW(eraw), .RDATA(rdata), .OPT_ONE(opt_one),
        .OPT_TWO(opt_two), .CLK_CFG(clk_cfg), .MON_CFG(mon_cfg), .PIN_MODE(pin_mode),
        .SERIAL_PORT_CLOCK(ser_clk), .INTERNAL_GEN_CLOCK(igen), .EXTERNAL_GEN_CLOCK(egen),
        .WDOG_TIMEOUT(wdog_to), .WDOG_ENABLE(wdog_en), .STOP_ALLOWED(stop_ok),
        .STOP_RECOVERY(stop_rec), .MON_RESET_OUT(mon_rst));
    // free-running 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end
    // compare any result, zero-extended to 32 bits
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // let the given number of edges pass, then sample mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // reset for 20 cycles; power-on reset too when por is set
    task automatic do_reset(input logic por);
        @(posedge mclk);
        arst_n <= 1'b0;
        por_n <= ~por;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        settle(1);
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    // one-cycle read strobe, data compared after the answering edge
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        check(rdata, exp);
    endtask
    // closing verdict, the only end of the run
    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, far beyond the roughly 130 cycles of the sequence
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end
    // main sequence
    initial begin
        do_reset(1'b1);
        check(opt_one, 8'h00);
        check(wdog_to, ocl_pkg::WDOG_LONG);
        check(wdog_en, 1'b1);
        check(stop_ok, 1'b0);
        check(mon_cfg, 4'hc);
        check(pin_mode, ocl_pkg::OCL_PINS_GPIO);
        // first write per register wins, second and unmapped ignored
        wr(ocl_pkg::ADDR_OPT_ONE, 8'hcf);
        wr(ocl_pkg::ADDR_OPT_ONE, 8'h00);
        wr(ocl_pkg::ADDR_OPT_TWO, 8'h1f);
        wr(16'h0020, 8'hff);
        settle(3);
        rd(16'h001e, 8'hcf);
        rd(16'h001f, 8'h1f);
        rd(16'h0020, 8'h00);
        check(opt_two, 8'h1f);
        check(wdog_to, ocl_pkg::WDOG_SHORT);
        check(wdog_en, 1'b0);
        check(stop_ok, 1'b1);
        check(stop_rec, ocl_pkg::REC_SHORT);
        check(mon_cfg, 4'hf);
        check(pin_mode, ocl_pkg::OCL_PINS_XTAL);
        check(clk_cfg, {4'hf, ocl_pkg::STAB_LONG});
        // stop with clocks kept, monitor tripping, serial on bus clock
        @(posedge mclk);
        stop <= 1'b1;
        iraw <= 1'b1;
        eraw <= 1'b1;
        bus_clk <= 1'b1;
        trip <= 1'b1;
        wake <= 1'b1;
        settle(5);
        check({igen, egen, ser_clk}, 3'h7);
        check(mon_rst, 1'b1);
        check(stop_rec, ocl_pkg::REC_LONG);
        // plain reset keeps the trip select only
        do_reset(1'b0);
        check(opt_one, 8'h08);
        wr(ocl_pkg::ADDR_OPT_ONE, 8'h38);
        wr(ocl_pkg::ADDR_OPT_TWO, 8'h04);
        settle(5);
        check(mon_cfg, 4'h1);
        check(mon_rst, 1'b0);
        check(stop_rec, ocl_pkg::REC_LONG);
        check({igen, egen, ser_clk}, 3'h0);
        check(pin_mode, ocl_pkg::OCL_PINS_GPIO);
        check(clk_cfg.stab_count, ocl_pkg::STAB_LONG);
        @(posedge mclk);
        wake <= 1'b0;
        settle(3);
        check(stop_rec, ocl_pkg::REC_LONG);
        // external clock alone, fast range
        do_reset(1'b0);
        wr(ocl_pkg::ADDR_OPT_TWO, 8'h08);
        settle(3);
        check(pin_mode, ocl_pkg::OCL_PINS_EXTCLK);
        check(clk_cfg, {4'h0, ocl_pkg::STAB_SHORT});
        do_reset(1'b1);
        check(opt_one, 8'h00);
        report_and_stop();
    end
endmodule // ocl_option_latches_tb_top
